// [hdl/trim_sync_device.sv]
// trim and multi-chip sync register bank of the converter
// assumes a controller on trim_sync_if holding req until ack; pins are asynchronous
//
// Behaviour
// - offset sign 1 makes offset negative
// - offset magnitude is 12-bit straight binary
// - host writes zero to offset reserved bits
// - full-scale 15-bit, default mid code 16384
// - codes above mid only in extended mode
// - coarse delay saturates from code 2432
// - delays apply only when adjust selected
// - duty stabilizer follows duty_cycle_correct bit
// - fine delay adds 0..63 on coarse
// - combined select enables adjust and filter
// - tank frequency is thermometer coded
// - reference delay saturates at code 639
// - phase select picks 0/90/180/270 degrees
// - follower syncs divider to reference input
// - ref outputs carry quarter-rate clock when enabled
// - data-clock reset honoured only when enabled
// - host keeps sync reserved bit zero
// - host writes zero to reserved nine
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module trim_sync_device (
    input wire logic clk,
    input wire logic nrst,
    trim_sync_if.device link,
    input wire logic extControlMode,
    input wire logic syncRefInput,
    input wire logic dataClockResetInput,
    output logic signed [12:0] offsetValue,
    output logic [14:0] fullScaleCode,
    output logic [11:0] coarseDelay,
    output logic [5:0] fineDelay,
    output logic dutyCycleCorrect,
    output logic jitterFilterOn,
    output logic [7:0] tankCenterFreq,
    output logic [9:0] refClockDelay,
    output logic [1:0] refPhaseSelect,
    output logic followerMode,
    output logic refClockOutA,
    output logic refClockOutB,
    output logic dataClockReset,
    output logic quarterClock
);
    import trim_sync_pkg::*;

    // ****************************************
    // register storage
    // ****************************************
    logic [15:0] resNine_ff;
    logic [15:0] qOffset_ff;
    logic [15:0] qFullScale_ff;
    logic [15:0] coarse_ff;
    logic [15:0] fineFilter_ff;
    logic [15:0] syncCtrl_ff;
    logic ack_ff;
    logic [15:0] rdata_ff;

    wire logic take = link.req && !ack_ff;
    wire logic wrEn = take && link.write;
    // reserved bits are masked on store, so reads show them as zero
    wire logic [15:0] wMasked9 = link.wdata & MASK_RESERVED_NINE;
    wire logic [15:0] wMaskedA = link.wdata & MASK_Q_OFFSET;
    wire logic [15:0] wMaskedB = link.wdata & MASK_Q_FULL_SCALE;
    wire logic [15:0] wMaskedC = link.wdata & MASK_COARSE_DELAY;
    wire logic [15:0] wMaskedD = link.wdata & MASK_FINE_FILTER;
    wire logic [15:0] wMaskedE = link.wdata & MASK_SYNC_CTRL;

    wire logic [15:0] readMux =
        (link.addr == ADDR_RESERVED_NINE) ? resNine_ff :
        (link.addr == ADDR_Q_OFFSET) ? qOffset_ff :
        (link.addr == ADDR_Q_FULL_SCALE) ? qFullScale_ff :
        (link.addr == ADDR_COARSE_DELAY) ? coarse_ff :
        (link.addr == ADDR_FINE_FILTER) ? fineFilter_ff :
        (link.addr == ADDR_SYNC_CTRL) ? syncCtrl_ff : 16'h0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resNine_ff <= RST_RESERVED_NINE;
            qOffset_ff <= RST_Q_OFFSET;
            qFullScale_ff <= RST_Q_FULL_SCALE;
            coarse_ff <= RST_COARSE_DELAY;
            fineFilter_ff <= RST_FINE_FILTER;
            syncCtrl_ff <= RST_SYNC_CTRL;
        end else if (wrEn) begin
            case (link.addr)
                ADDR_RESERVED_NINE: resNine_ff <= wMasked9;
                ADDR_Q_OFFSET: qOffset_ff <= wMaskedA;
                ADDR_Q_FULL_SCALE: qFullScale_ff <= wMaskedB;
                ADDR_COARSE_DELAY: coarse_ff <= wMaskedC;
                ADDR_FINE_FILTER: fineFilter_ff <= wMaskedD;
                ADDR_SYNC_CTRL: syncCtrl_ff <= wMaskedE;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            ack_ff <= take;
            rdata_ff <= take ? readMux : rdata_ff;
        end
    end
    assign link.ack = ack_ff;
    assign link.rdata = rdata_ff;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] extSync_ff;
    logic [1:0] refSync_ff;
    logic [1:0] dclkSync_ff;
    logic refPrev_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extSync_ff <= 2'h0;
            refSync_ff <= 2'h0;
            dclkSync_ff <= 2'h0;
            refPrev_ff <= 1'b0;
        end else begin
            extSync_ff <= {extSync_ff[0], extControlMode};
            refSync_ff <= {refSync_ff[0], syncRefInput};
            dclkSync_ff <= {dclkSync_ff[0], dataClockResetInput};
            refPrev_ff <= refSync_ff[1];
        end
    end
    wire logic extMode = extSync_ff[1];
    wire logic refRise = refSync_ff[1] && !refPrev_ff;

    // ****************************************
    // decoded controls
    // ****************************************
    wire logic [11:0] offMag = qOffset_ff[11:0];
    wire logic offNeg = qOffset_ff[OFS_SIGN_BIT];
    wire logic signed [12:0] offPos = $signed({1'b0, offMag});
    wire logic signed [12:0] nxt_offset = offNeg ? -offPos : offPos;
    wire logic [14:0] fsRaw = qFullScale_ff[14:0];
    // outside extended mode the range tops out at the nominal mid code
    wire logic [14:0] nxt_fullScale =
        (!extMode && fsRaw > FULL_SCALE_MID) ? FULL_SCALE_MID : fsRaw;
    wire logic filterSel = fineFilter_ff[ADJ_FILTER_BIT];
    wire logic adjOn = filterSel || coarse_ff[ADJ_SELECT_BIT];
    wire logic [11:0] coarseRaw = coarse_ff[15:COARSE_LSB];
    wire logic [11:0] coarseSat = (coarseRaw > COARSE_MAX) ? COARSE_MAX : coarseRaw;
    wire logic [11:0] nxt_coarse = adjOn ? coarseSat : 12'h000;
    wire logic [5:0] nxt_fine = adjOn ? fineFilter_ff[15:FINE_LSB] : 6'h00;
    wire logic [9:0] refRaw = syncCtrl_ff[15:REF_DELAY_LSB];
    wire logic [9:0] nxt_refDelay = (refRaw > REF_DELAY_MAX) ? REF_DELAY_MAX : refRaw;
    wire logic follower = syncCtrl_ff[FOLLOWER_BIT];
    wire logic refOutOn = !syncCtrl_ff[REF_OUT_DIS_BIT];
    wire logic dataRstOn = !syncCtrl_ff[DATA_RST_DIS_BIT];

    // ****************************************
    // quarter-rate divider
    // ****************************************
    logic [1:0] div_ff;
    // a follower restarts its divider on each rising reference edge so all chips align
    wire logic [1:0] nxt_div = (follower && refRise) ? 2'h0 : div_ff + 2'h1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offsetValue <= 13'sh0;
            fullScaleCode <= RST_Q_FULL_SCALE[14:0];
            coarseDelay <= 12'h000;
            fineDelay <= 6'h00;
            dutyCycleCorrect <= RST_COARSE_DELAY[DUTY_CORRECT_BIT];
            jitterFilterOn <= 1'b0;
            tankCenterFreq <= 8'h00;
            refClockDelay <= 10'h000;
            refPhaseSelect <= 2'h0;
            followerMode <= 1'b0;
            refClockOutA <= 1'b0;
            refClockOutB <= 1'b0;
            dataClockReset <= 1'b0;
            quarterClock <= 1'b0;
        end else begin
            offsetValue <= nxt_offset;
            fullScaleCode <= nxt_fullScale;
            coarseDelay <= nxt_coarse;
            fineDelay <= nxt_fine;
            dutyCycleCorrect <= coarse_ff[DUTY_CORRECT_BIT];
            jitterFilterOn <= filterSel;
            tankCenterFreq <= fineFilter_ff[7:0];
            refClockDelay <= nxt_refDelay;
            refPhaseSelect <= syncCtrl_ff[PHASE_LSB +: 2];
            followerMode <= follower;
            refClockOutA <= refOutOn && div_ff[1];
            refClockOutB <= refOutOn && div_ff[1];
            dataClockReset <= dataRstOn && dclkSync_ff[1];
            quarterClock <= div_ff[1];
        end
    end
endmodule : trim_sync_device
`default_nettype wire

// [hdl/trim_sync_host.sv]
// controller end: takes AXI4-Lite orders and runs link transfers
// assumes one AXI4-Lite master; one link transfer at a time
`timescale 1ns/1ns
`default_nettype none
module trim_sync_host (
    input wire logic clk,
    input wire logic nrst,
    trim_sync_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import trim_sync_pkg::*;

    // ****************************************
    // AXI write side
    // ****************************************
    logic busy_ff;
    logic [15:0] lastRead_ff;
    wire logic wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire logic cmdHit = (s_axi_awaddr == AXI_CMD);
    wire logic wrMapped = cmdHit || (s_axi_awaddr == AXI_STATUS);
    // orders that arrive while a transfer runs are dropped, not queued
    wire logic start = wrTake && cmdHit && s_axi_wstrb[3] && !busy_ff;
    wire logic [3:0] cmdAddr = s_axi_wdata[CMD_ADDR_LSB +: 4];
    wire logic [15:0] cmdMask =
        (cmdAddr == ADDR_RESERVED_NINE) ? MASK_RESERVED_NINE :
        (cmdAddr == ADDR_Q_OFFSET) ? MASK_Q_OFFSET :
        (cmdAddr == ADDR_Q_FULL_SCALE) ? MASK_Q_FULL_SCALE :
        (cmdAddr == ADDR_COARSE_DELAY) ? MASK_COARSE_DELAY :
        (cmdAddr == ADDR_FINE_FILTER) ? MASK_FINE_FILTER :
        (cmdAddr == ADDR_SYNC_CTRL) ? MASK_SYNC_CTRL : 16'hffff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wrTake;
            s_axi_wready <= wrTake;
            // response waits for the handshake edge, where address and data still stand
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // link transfer
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
            link.req <= 1'b0;
            link.write <= 1'b0;
            link.addr <= 4'h0;
            link.wdata <= 16'h0000;
            lastRead_ff <= 16'h0000;
        end else if (start) begin
            busy_ff <= 1'b1;
            link.req <= 1'b1;
            link.write <= s_axi_wdata[CMD_WRITE_BIT];
            link.addr <= cmdAddr;
            link.wdata <= s_axi_wdata[15:0] & cmdMask;
        end else if (link.ack) begin
            busy_ff <= 1'b0;
            link.req <= 1'b0;
            lastRead_ff <= link.write ? lastRead_ff : link.rdata;
        end
    end

    // ****************************************
    // AXI read side
    // ****************************************
    wire logic rdTake = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire logic [31:0] statusWord = {15'h0000, busy_ff, lastRead_ff};
    wire logic [31:0] cmdWord = {7'h00, link.write, 4'h0, link.addr, link.wdata};
    wire logic rdStatus = (s_axi_araddr == AXI_STATUS);
    wire logic rdCmd = (s_axi_araddr == AXI_CMD);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rdTake;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdStatus ? statusWord : (rdCmd ? cmdWord : 32'h00000000);
                s_axi_rresp <= (rdStatus || rdCmd) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : trim_sync_host
`default_nettype wire

// [hdl/trim_sync_if.sv]
// register link between the controller end and the device end
// assumes both ends share clk; req is held until ack
`timescale 1ns/1ns
`default_nettype none
interface trim_sync_if (
    input wire logic clk
);
    logic req;
    logic write;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    modport device (input req, write, addr, wdata, output rdata, ack);
    modport host (output req, write, addr, wdata, input rdata, ack);
endinterface : trim_sync_if
`default_nettype wire

// [hdl/trim_sync_pkg.sv]
// constants shared by the trim/sync register bank and its controller
// assumes one 100 MHz clock domain for both ends
package trim_sync_pkg;
    // ****************************************
    // register addresses (4-bit link address)
    // ****************************************
    localparam logic [3:0] ADDR_RESERVED_NINE = 4'h9;
    localparam logic [3:0] ADDR_Q_OFFSET = 4'ha;
    localparam logic [3:0] ADDR_Q_FULL_SCALE = 4'hb;
    localparam logic [3:0] ADDR_COARSE_DELAY = 4'hc;
    localparam logic [3:0] ADDR_FINE_FILTER = 4'hd;
    localparam logic [3:0] ADDR_SYNC_CTRL = 4'he;
    // ****************************************
    // power-on values
    // ****************************************
    localparam logic [15:0] RST_RESERVED_NINE = 16'h0000;
    localparam logic [15:0] RST_Q_OFFSET = 16'h0000;
    localparam logic [15:0] RST_Q_FULL_SCALE = 16'h4000;
    localparam logic [15:0] RST_COARSE_DELAY = 16'h0004;
    localparam logic [15:0] RST_FINE_FILTER = 16'h0000;
    localparam logic [15:0] RST_SYNC_CTRL = 16'h0003;
    // ****************************************
    // writable-bit masks (reserved bits clear)
    // ****************************************
    localparam logic [15:0] MASK_RESERVED_NINE = 16'h0000;
    localparam logic [15:0] MASK_Q_OFFSET = 16'h1fff;
    localparam logic [15:0] MASK_Q_FULL_SCALE = 16'h7fff;
    localparam logic [15:0] MASK_COARSE_DELAY = 16'hfffc;
    localparam logic [15:0] MASK_FINE_FILTER = 16'hfdff;
    localparam logic [15:0] MASK_SYNC_CTRL = 16'hffdf;
    // ****************************************
    // field positions
    // ****************************************
    localparam int OFS_SIGN_BIT = 12;
    localparam int COARSE_LSB = 4;
    localparam int ADJ_SELECT_BIT = 3;
    localparam int DUTY_CORRECT_BIT = 2;
    localparam int FINE_LSB = 10;
    localparam int ADJ_FILTER_BIT = 8;
    localparam int REF_DELAY_LSB = 6;
    localparam int PHASE_LSB = 3;
    localparam int FOLLOWER_BIT = 2;
    localparam int REF_OUT_DIS_BIT = 1;
    localparam int DATA_RST_DIS_BIT = 0;
    // ****************************************
    // code limits
    // ****************************************
    localparam logic [14:0] FULL_SCALE_MID = 15'h4000;
    localparam logic [11:0] COARSE_MAX = 12'h97f;
    localparam logic [9:0] REF_DELAY_MAX = 10'h27f;
    // ****************************************
    // controller registers on AXI4-Lite
    // ****************************************
    localparam logic [3:0] AXI_CMD = 4'h0;
    localparam logic [3:0] AXI_STATUS = 4'h4;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_WRITE_BIT = 24;
    localparam int STATUS_BUSY_BIT = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : trim_sync_pkg

// [test/trim_sync_props.sv]
// link checker between controller end and register bank end
// assumes one clk domain; nrst is asynchronous, active low
`timescale 1ns/1ns
`default_nettype none
module trim_sync_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic write,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack
);
    import trim_sync_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // helper logic
    // ****************************************
    wire logic take;
    logic [15:0] lastOfs_ff;
    logic [15:0] nxt_lastOfs;
    function automatic logic [15:0] rdMask(input logic [3:0] a);
        case (a)
            ADDR_Q_OFFSET: return MASK_Q_OFFSET;
            ADDR_Q_FULL_SCALE: return MASK_Q_FULL_SCALE;
            ADDR_COARSE_DELAY: return MASK_COARSE_DELAY;
            ADDR_FINE_FILTER: return MASK_FINE_FILTER;
            ADDR_SYNC_CTRL: return MASK_SYNC_CTRL;
            default: return 16'h0000;
        endcase
    endfunction : rdMask
    assign take = req && !ack;
    assign nxt_lastOfs = (take && write && addr == ADDR_Q_OFFSET) ? (wdata & MASK_Q_OFFSET)
                                                                  : lastOfs_ff;
    // only one register is shadowed; the bench covers the others by readback
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lastOfs_ff <= RST_Q_OFFSET;
        end else begin
            lastOfs_ff <= nxt_lastOfs;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_latency;
        take |=> ack;
    endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("ack not one cycle after take");
    property p_ack_cause;
        ack |-> $past(req) && !$past(ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
    property p_req_hold;
        take |=> req && $stable(addr) && $stable(write) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
    property p_req_drop;
        ack |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    property p_rdata_hold;
        !take |=> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_rsvd_zero;
        take && !write |=> (rdata & ~rdMask($past(addr))) == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");
    property p_nine_zero;
        take && !write && addr == ADDR_RESERVED_NINE |=> rdata == 16'h0000;
    endproperty
    a_nine_zero: assert property (p_nine_zero) else $error("reserved register nonzero");
    property p_ofs_readback;
        take && !write && addr == ADDR_Q_OFFSET |=> rdata == lastOfs_ff;
    endproperty
    a_ofs_readback: assert property (p_ofs_readback) else $error("offset readback wrong");
endmodule : trim_sync_props
`default_nettype wire

// [test/trim_sync_test.sv]
// bench: AXI4-Lite master drives the controller, which reaches the register bank
// assumes both ends joined by trim_sync_if on one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module trim_sync_test;
    import trim_sync_pkg::*;
    logic clk = 1'b0, nrst = 1'b0;
    logic extControlMode = 1'b0, syncRefInput = 1'b0, dataClockResetInput = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic signed [12:0] offsetValue;
    logic [14:0] fullScaleCode;
    logic [11:0] coarseDelay;
    logic [5:0] fineDelay;
    logic [7:0] tankCenterFreq;
    logic [9:0] refClockDelay;
    logic [1:0] refPhaseSelect;
    logic dutyCycleCorrect, jitterFilterOn, followerMode, refClockOutA, refClockOutB;
    logic dataClockReset, quarterClock;
    int num_errors = 0, checks_done = 0;
    localparam logic [3:0] ADDRS [6] = '{ADDR_RESERVED_NINE, ADDR_Q_OFFSET, ADDR_Q_FULL_SCALE,
        ADDR_COARSE_DELAY, ADDR_FINE_FILTER, ADDR_SYNC_CTRL};
    localparam logic [15:0] RSTS [6] = '{RST_RESERVED_NINE, RST_Q_OFFSET, RST_Q_FULL_SCALE,
        RST_COARSE_DELAY, RST_FINE_FILTER, RST_SYNC_CTRL};
    trim_sync_if trim_sync_if_inst (.clk(clk));
    trim_sync_device trim_sync_device_inst (.link(trim_sync_if_inst), .*);
    trim_sync_host trim_sync_host_inst (.link(trim_sync_if_inst), .*);
    trim_sync_props trim_sync_props_inst (.clk(clk), .nrst(nrst), .req(trim_sync_if_inst.req),
        .write(trim_sync_if_inst.write), .addr(trim_sync_if_inst.addr),
        .wdata(trim_sync_if_inst.wdata), .rdata(trim_sync_if_inst.rdata),
        .ack(trim_sync_if_inst.ack));
    always #5 clk = ~clk;
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge clk);
        while (!s_axi_awready) @(posedge clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (!s_axi_bvalid) @(posedge clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (!s_axi_arready) @(posedge clk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // one link transfer: command, then poll until the controller is idle
    task automatic link_op(input logic w, input logic [3:0] a, input logic [15:0] d,
                           output logic [15:0] q);
        logic [1:0] r;
        logic [31:0] s;
        axi_write(AXI_CMD, {7'h00, w, 4'h0, a, d}, r);
        do axi_read(AXI_STATUS, s, r); while (s[STATUS_BUSY_BIT] !== 1'b0);
        q = s[15:0];
    endtask : link_op
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        link_op(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        link_op(1'b0, a, 16'h0000, q);
    endtask : rd
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [15:0] q;
        for (int i = 0; i < 6; i++) begin
            rd(ADDRS[i], q);
            `CHK(q, RSTS[i])
        end
        `CHK(fullScaleCode, 15'h4000)
        `CHK(dutyCycleCorrect, 1'b1)
        `CHK(refClockOutA, 1'b0)
        `CHK(dataClockReset, 1'b0)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_offset;
        logic [15:0] q;
        wr(ADDR_Q_OFFSET, 16'hffff);
        rd(ADDR_Q_OFFSET, q);
        `CHK(q, 16'h1fff)
        `CHK(offsetValue, 13'h1001)
        wr(ADDR_Q_OFFSET, 16'h0800);
        `CHK(offsetValue, 13'h0800)
        wr(ADDR_Q_OFFSET, 16'h1000);
        `CHK(offsetValue, 13'h0000)
        $display("t_offset done");
    endtask : t_offset
    task automatic t_full_scale;
        logic [15:0] q;
        wr(ADDR_Q_FULL_SCALE, 16'hffff);
        rd(ADDR_Q_FULL_SCALE, q);
        `CHK(q, 16'h7fff)
        `CHK(fullScaleCode, 15'h4000)
        wr(ADDR_Q_FULL_SCALE, 16'h3fff);
        `CHK(fullScaleCode, 15'h3fff)
        wr(ADDR_Q_FULL_SCALE, 16'h7fff);
        extControlMode <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(fullScaleCode, 15'h7fff)
        $display("t_full_scale done");
    endtask : t_full_scale
    task automatic t_aperture;
        logic [15:0] q;
        wr(ADDR_COARSE_DELAY, {12'h980, 4'h0});
        wr(ADDR_FINE_FILTER, {6'h3f, 2'b00, 8'h0f});
        `CHK(coarseDelay, 12'h000)
        `CHK(fineDelay, 6'h00)
        `CHK(dutyCycleCorrect, 1'b0)
        `CHK(tankCenterFreq, 8'h0f)
        `CHK(jitterFilterOn, 1'b0)
        wr(ADDR_COARSE_DELAY, {12'h980, 4'h8});
        `CHK(coarseDelay, 12'h97f)
        `CHK(fineDelay, 6'h3f)
        wr(ADDR_COARSE_DELAY, {12'h97f, 4'h7});
        wr(ADDR_FINE_FILTER, {6'h01, 2'b11, 8'hff});
        `CHK(coarseDelay, 12'h97f)
        `CHK(fineDelay, 6'h01)
        `CHK(jitterFilterOn, 1'b1)
        rd(ADDR_COARSE_DELAY, q);
        `CHK(q, 16'h97f4)
        rd(ADDR_FINE_FILTER, q);
        `CHK(q, 16'h05ff)
        $display("t_aperture done");
    endtask : t_aperture
    task automatic t_sync;
        logic [15:0] q;
        logic [4:0] n;
        logic prev;
        wr(ADDR_SYNC_CTRL, {10'h3ff, 1'b1, 2'b11, 3'b000});
        rd(ADDR_SYNC_CTRL, q);
        `CHK(q, 16'hffd8)
        `CHK(refClockDelay, 10'h27f)
        `CHK(followerMode, 1'b0)
        `CHK(dataClockReset, 1'b1)
        n = 5'h00;
        @(posedge clk);
        #1;
        prev = refClockOutA;
        repeat (16) begin
            @(posedge clk);
            #1;
            if (refClockOutA !== prev) n++;
            prev = refClockOutA;
            `CHK(refClockOutB, refClockOutA)
        end
        `CHK(n, 5'h08)
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_SYNC_CTRL, {10'h27c + p[9:0], 1'b0, p[1:0], 3'b111});
            `CHK(refPhaseSelect, p[1:0])
            `CHK(refClockDelay, 10'h27c + p[9:0])
        end
        `CHK(followerMode, 1'b1)
        `CHK(refClockOutA, 1'b0)
        `CHK(dataClockReset, 1'b0)
        syncRefInput <= 1'b1;
        repeat (4) @(posedge clk);
        #1 `CHK(quarterClock, 1'b0)
        @(posedge clk);
        #1 `CHK(quarterClock, 1'b0)
        @(posedge clk);
        #1 `CHK(quarterClock, 1'b1)
        $display("t_sync done");
    endtask : t_sync
    task automatic t_unmapped;
        logic [15:0] q;
        logic [31:0] s;
        logic [1:0] r;
        wr(ADDR_RESERVED_NINE, 16'hffff);
        rd(ADDR_RESERVED_NINE, q);
        `CHK(q, 16'h0000)
        wr(4'h3, 16'h1234);
        rd(4'h3, q);
        `CHK(q, 16'h0000)
        axi_read(4'h8, s, r);
        `CHK(r, RESP_SLVERR)
        axi_write(4'hc, 32'h0, r);
        `CHK(r, RESP_SLVERR)
        rd(ADDR_Q_OFFSET, q);
        `CHK(q, 16'h1000)
        axi_read(AXI_CMD, s, r);
        `CHK(s, {12'h000, ADDR_Q_OFFSET, 16'h0000})
        $display("t_unmapped done");
    endtask : t_unmapped
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // the whole sequence needs a few hundred cycles; the margin is wide
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_offset();
        t_full_scale();
        t_aperture();
        t_sync();
        t_unmapped();
        print_verdict();
    end
endmodule : trim_sync_test
`default_nettype wire
